// ---- design/dsw_defines.svh ----
// Constants for the drive status word sequencer: bit positions,
// command word values, host register offsets and timing.
// Assumes inclusion by bare name from design files.
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// Status word bit positions
`define DSW_SW_SWITCH_ON_READY 0
`define DSW_SW_OPERATE_READY 1
`define DSW_SW_OP_ENABLED 2
`define DSW_SW_FAULT_FLAG 3
`define DSW_SW_SECOND_OFF_INACTIVE 4
`define DSW_SW_THIRD_OFF_INACTIVE 5
`define DSW_SW_SWITCH_ON_INHIBIT 6
`define DSW_SW_ALARM 7
`define DSW_SW_REFERENCE_REACHED 8
`define DSW_SW_REMOTE 9
`define DSW_SW_ABOVE_LIMIT 10
`define DSW_SW_LOCATION_TWO 11
`define DSW_SW_RUN_PERMIT 12
`define DSW_SW_RESET 16'h0000

// Command word bit positions
`define DSW_CMD_FIRST_OFF 0
`define DSW_CMD_SECOND_OFF 1
`define DSW_CMD_THIRD_OFF 2
`define DSW_CMD_OPERATE 3
`define DSW_CMD_RAMP_OUT 5
`define DSW_CMD_RAMP_IN 6
`define DSW_CMD_FAULT_RESET 7
`define DSW_CMD_LOCATION 11
`define DSW_CMD_IGNORE_MASK 16'hfbff
`define DSW_CMD_RESET 16'h0000

// Start sequence command words
`define DSW_CMD_PREPARE 16'h0006
`define DSW_CMD_SWITCH_ON 16'h0007
`define DSW_CMD_ENABLE 16'h000f
`define DSW_CMD_RAMP_RELEASE 16'h002f
`define DSW_CMD_RUN 16'h006f

// Host register byte offsets
`define DSW_REG_COMMAND 4'h0
`define DSW_REG_STATUS 4'h4
`define DSW_STAT_PENDING 16
`define DSW_STAT_GUARD 17

// AXI responses
`define DSW_RESP_OKAY 2'h0
`define DSW_RESP_SLVERR 2'h2

// Settle time after ready-to-switch-on, in ms, and clock in kHz
`define DSW_GUARD_MS 100
`define DSW_CLK_KHZ 250000

`endif

// ---- design/dsw_pkg.sv ----
// Types shared by both ends of the drive status word link.
// Assumes dsw_defines.svh is compiled alongside.
package dsw_pkg;

	typedef enum logic [2:0] {
		DSW_NOT_READY,
		DSW_INHIBITED,
		DSW_READY_SWITCH_ON,
		DSW_READY_OPERATE,
		DSW_OP_ENABLED,
		DSW_RAMP_ACCEL,
		DSW_OPERATING,
		DSW_FAULT
	} dsw_state_t;

	typedef struct packed {
		dsw_state_t state;
		logic [15:0] cmd;
		logic [15:0] status;
		logic run;
		logic ramp_out_release;
		logic ramp_in_release;
	} dsw_dev_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic aw_got;
		logic w_got;
		logic [3:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic pending;
		logic [15:0] cmd_reg;
		logic [15:0] cmd_word;
		logic cmd_valid;
		logic [31:0] guard;
		logic ready_prev;
	} dsw_host_t;

	typedef struct packed {
		logic above;
	} dsw_hyst_t;

endpackage

// ---- design/dsw_link_if.sv ----
// Link between the fieldbus master end and the drive end.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dsw_link_if;
	logic [15:0] command_word;
	logic command_valid;
	logic [15:0] status_word;

	modport device (
		input command_word,
		input command_valid,
		output status_word
	);

	modport host (
		output command_word,
		output command_valid,
		input status_word
	);
endinterface
`default_nettype wire

// ---- design/dsw_limit_hyst.sv ----
// Supervision comparator with hysteresis between a high and low limit.
// Assumes value and limits come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dsw_limit_hyst #(
	parameter int unsigned W = 16
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] value_i,
	input wire logic [W-1:0] high_i,
	input wire logic [W-1:0] low_i,
	output logic above_o
);
	import dsw_pkg::*;

	dsw_hyst_t q, d;

	always_comb begin
		d = q;
		if (value_i >= high_i) begin
			d.above = 1'b1;
		end else if (value_i < low_i) begin
			d.above = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign above_o = q.above;
endmodule
`default_nettype wire

// ---- design/dsw_device.sv ----
// Drive end: start-stop state sequence driven by command words and the
// status word reported back to the fieldbus master.
// Assumes all user-side inputs come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"

// What this block does
// - Present status word for master to read
// - Bits 0-5: readiness, fault, off interlocks
// - Bit 6 shows switch-on inhibit
// - Bit 7 shows warning or alarm
// - Bit 8 shows actual within reference tolerance
// - Bit 9 shows remote control location
// - Bit 10 supervision with high/low hysteresis
// - Bit 11 shows second external location
// - Bit 12 shows external run permit
// - Command bit 10 ignored; standard profile
// - Power-up state is not ready
// - Command 0x0006 gives ready to switch on
// - Master waits 100 ms after ready
// - Command 0x0007 gives ready to operate
// - Command 0x000F gives operation enabled, ramp held
// - Command 0x002F releases ramp output
// - Command 0x006F releases ramp input, operating
// - Fault reset from other sources too
// - Bit 3 enables, clearing inhibits operation
// - Rising bit 7 resets fault to inhibited
module dsw_device #(
	parameter int unsigned VW = 16
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	dsw_link_if.device link,
	input wire logic fault_detect_i,
	input wire logic fault_reset_i,
	input wire logic alarm_i,
	input wire logic remote_i,
	input wire logic external_run_permit_i,
	input wire logic [VW-1:0] actual_i,
	input wire logic [VW-1:0] reference_i,
	input wire logic [VW-1:0] tolerance_i,
	input wire logic [VW-1:0] supervised_i,
	input wire logic [VW-1:0] limit_high_i,
	input wire logic [VW-1:0] limit_low_i,
	output var dsw_pkg::dsw_state_t state_o,
	output logic run_o,
	output logic ramp_out_release_o,
	output logic ramp_in_release_o
);
	import dsw_pkg::*;

	dsw_dev_t q, d;
	logic above_limit;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [VW-1:0] abs_diff(
		input logic [VW-1:0] a,
		input logic [VW-1:0] b
	);
		abs_diff = (a >= b) ? a - b : b - a;
	endfunction

	function automatic logic at_least(
		input dsw_state_t s,
		input dsw_state_t floor_s
	);
		at_least = (s != DSW_FAULT) && (s >= floor_s);
	endfunction

	dsw_limit_hyst #(
		.W(VW)
	) u_hyst (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.value_i(supervised_i),
		.high_i(limit_high_i),
		.low_i(limit_low_i),
		.above_o(above_limit)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		logic [15:0] cw;
		logic got;
		logic off_hit;
		logic clear_fault;
		cw = q.cmd;
		got = 1'b0;
		off_hit = 1'b0;
		clear_fault = 1'b0;
		d = q;
		if (link.command_valid) begin
			cw = link.command_word & `DSW_CMD_IGNORE_MASK;
			got = 1'b1;
		end
		d.cmd = cw;
		off_hit = !cw[`DSW_CMD_SECOND_OFF] || !cw[`DSW_CMD_THIRD_OFF];
		clear_fault = fault_reset_i ||
			(got && cw[`DSW_CMD_FAULT_RESET] &&
			!q.cmd[`DSW_CMD_FAULT_RESET]);

		if (fault_detect_i && q.state != DSW_FAULT) begin
			d.state = DSW_FAULT;
		end else begin
			case (q.state)
			DSW_FAULT: begin
				if (clear_fault) begin
					d.state = DSW_INHIBITED;
				end
			end
			DSW_NOT_READY: begin
				if (got && off_hit) begin
					d.state = DSW_INHIBITED;
				end else if (got && !cw[`DSW_CMD_FIRST_OFF]) begin
					d.state = DSW_READY_SWITCH_ON;
				end
			end
			DSW_INHIBITED: begin
				if (got && !off_hit && !cw[`DSW_CMD_FIRST_OFF]) begin
					d.state = DSW_NOT_READY;
				end
			end
			default: begin
				// Running branch: each command steps up at most one state; off and disable words can drop several states at once
				if (got && off_hit) begin
					d.state = DSW_INHIBITED;
				end else if (got && !cw[`DSW_CMD_FIRST_OFF]) begin
					d.state = DSW_READY_SWITCH_ON;
				end else if (q.state == DSW_READY_SWITCH_ON) begin
					if (got) begin
						d.state = DSW_READY_OPERATE;
					end
				end else if (q.state == DSW_READY_OPERATE) begin
					if (got && cw[`DSW_CMD_OPERATE] &&
						external_run_permit_i) begin
						d.state = DSW_OP_ENABLED;
					end
				end else if ((got && !cw[`DSW_CMD_OPERATE]) ||
					!external_run_permit_i) begin
					d.state = DSW_READY_OPERATE;
				end else if (q.state == DSW_OP_ENABLED) begin
					if (got && cw[`DSW_CMD_RAMP_OUT]) begin
						d.state = DSW_RAMP_ACCEL;
					end
				end else if (got && !cw[`DSW_CMD_RAMP_OUT]) begin
					d.state = DSW_OP_ENABLED;
				end else if (q.state == DSW_RAMP_ACCEL) begin
					if (got && cw[`DSW_CMD_RAMP_IN]) begin
						d.state = DSW_OPERATING;
					end
				end else if (got && !cw[`DSW_CMD_RAMP_IN]) begin
					d.state = DSW_RAMP_ACCEL;
				end
			end
			endcase
		end

		// Drive-side controls follow the new state
		d.run = at_least(d.state, DSW_OP_ENABLED);
		d.ramp_out_release = at_least(d.state, DSW_RAMP_ACCEL);
		d.ramp_in_release = (d.state == DSW_OPERATING);

		// ----------------------------------------
		// Status word
		// ----------------------------------------
		d.status = `DSW_SW_RESET;
		d.status[`DSW_SW_SWITCH_ON_READY] =
			at_least(d.state, DSW_READY_SWITCH_ON);
		d.status[`DSW_SW_OPERATE_READY] =
			at_least(d.state, DSW_READY_OPERATE);
		d.status[`DSW_SW_OP_ENABLED] =
			at_least(d.state, DSW_OP_ENABLED);
		d.status[`DSW_SW_FAULT_FLAG] = (d.state == DSW_FAULT);
		d.status[`DSW_SW_SECOND_OFF_INACTIVE] =
			cw[`DSW_CMD_SECOND_OFF];
		d.status[`DSW_SW_THIRD_OFF_INACTIVE] =
			cw[`DSW_CMD_THIRD_OFF];
		d.status[`DSW_SW_SWITCH_ON_INHIBIT] =
			(d.state == DSW_INHIBITED);
		d.status[`DSW_SW_ALARM] = alarm_i;
		d.status[`DSW_SW_REFERENCE_REACHED] =
			abs_diff(actual_i, reference_i) <= tolerance_i;
		d.status[`DSW_SW_REMOTE] = remote_i;
		d.status[`DSW_SW_ABOVE_LIMIT] = above_limit;
		d.status[`DSW_SW_LOCATION_TWO] = cw[`DSW_CMD_LOCATION];
		d.status[`DSW_SW_RUN_PERMIT] = external_run_permit_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q.state <= DSW_NOT_READY;
			q.cmd <= `DSW_CMD_RESET;
			q.status <= `DSW_SW_RESET;
			q.run <= 1'b0;
			q.ramp_out_release <= 1'b0;
			q.ramp_in_release <= 1'b0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign link.status_word = q.status;
	assign state_o = q.state;
	assign run_o = q.run;
	assign ramp_out_release_o = q.ramp_out_release;
	assign ramp_in_release_o = q.ramp_in_release;
endmodule
`default_nettype wire

// ---- design/dsw_host.sv ----
// Master end: software queues command words over AXI4-Lite, the host
// forwards them and reads back the status word.
// Assumes the AXI master and the link share clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"
module dsw_host #(
	parameter int unsigned GUARD_CYCLES = `DSW_GUARD_MS * `DSW_CLK_KHZ
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	dsw_link_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dsw_pkg::*;

	dsw_host_t q, d;

	always_comb begin
		logic rdy_now;
		rdy_now = link.status_word[`DSW_SW_SWITCH_ON_READY];
		d = q;
		// ----------------------------------------
		// Settle guard and command forwarding
		// ----------------------------------------
		d.ready_prev = rdy_now;
		if (rdy_now && !q.ready_prev) begin
			d.guard = GUARD_CYCLES;
		end else if (q.guard != 32'h0) begin
			d.guard = q.guard - 32'h1;
		end
		d.cmd_valid = 1'b0;
		// Hold the queue in the cycle before the guard loads, too
		if (q.pending && q.guard == 32'h0 && !q.cmd_valid &&
			!(rdy_now && !q.ready_prev)) begin
			d.cmd_valid = 1'b1;
			d.cmd_word = q.cmd_reg;
			d.pending = 1'b0;
		end
		// ----------------------------------------
		// Write channel
		// ----------------------------------------
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (d.aw_got && d.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `DSW_RESP_OKAY;
			case (d.waddr)
			`DSW_REG_COMMAND: begin
				if (d.wstrb[0]) begin
					d.cmd_reg[7:0] = d.wdata[7:0];
				end
				if (d.wstrb[1]) begin
					d.cmd_reg[15:8] = d.wdata[15:8];
				end
				d.pending = 1'b1;
			end
			`DSW_REG_STATUS: begin
			end
			default: begin
				d.bresp = `DSW_RESP_SLVERR;
			end
			endcase
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready = !d.w_got && !d.bvalid;
		// ----------------------------------------
		// Read channel
		// ----------------------------------------
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = `DSW_RESP_OKAY;
			d.rdata = 32'h0;
			case (s_axi_araddr)
			`DSW_REG_COMMAND: begin
				d.rdata[15:0] = q.cmd_reg;
			end
			`DSW_REG_STATUS: begin
				d.rdata[15:0] = link.status_word;
				d.rdata[`DSW_STAT_PENDING] = q.pending;
				d.rdata[`DSW_STAT_GUARD] = (q.guard != 32'h0);
			end
			default: begin
				d.rresp = `DSW_RESP_SLVERR;
			end
			endcase
		end
		d.arready = !d.rvalid;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign link.command_word = q.cmd_word;
	assign link.command_valid = q.cmd_valid;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
endmodule
`default_nettype wire

// ---- tb/dsw_link_monitor.sv ----
// Checker on the link between the host and device ends.
// Assumes one clock; placed beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module dsw_link_monitor (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] command_word,
	input wire logic command_valid,
	input wire logic [15:0] status_word
);
	logic [15:0] last_q;
	logic [15:0] cw;
	logic [15:0] sw;
	assign cw = command_word & 16'hfbff;
	assign sw = status_word;
	// Previous received word, for the fault reset edge
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_q <= 16'h0000;
		end else if (command_valid) begin
			last_q <= command_word;
		end
	end
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	power_up_a: assert property (
		$rose(resetn_i) |-> sw == 16'h0000 && !command_valid)
		else $error("status not clear after reset");
	valid_pulse_a: assert property (
		command_valid |=> !command_valid)
		else $error("command valid longer than one cycle");
	unused_zero_a: assert property (
		sw[15:13] == 3'h0)
		else $error("unused status bits set");
	inhibit_flag_a: assert property (
		sw[6] |-> sw[2:0] == 3'h0)
		else $error("inhibit shown with ready bits");
	fault_flag_a: assert property (
		sw[3] |-> sw[2:0] == 3'h0 && !sw[6])
		else $error("fault shown with ready bits");
	start_ready_a: assert property (
		command_valid && cw == 16'h0006 && sw[3:0] == 4'h0 && !sw[6]
		|-> ##2 sw[1:0] == 2'b01)
		else $error("prepare word did not give ready to switch on");
	switch_on_a: assert property (
		command_valid && cw[2:0] == 3'h7 && sw[1:0] == 2'b01 && !sw[3]
		|-> ##2 sw[1])
		else $error("switch on word did not give ready to operate");
	enable_a: assert property (
		command_valid && cw[3:0] == 4'hf && sw[2:0] == 3'h3 && sw[12]
		&& !sw[3] |-> ##2 sw[2])
		else $error("enable word did not enable operation");
	inhibit_op_a: assert property (
		command_valid && cw[3:0] == 4'h7 && sw[2] && !sw[3]
		|-> ##2 sw[2:0] == 3'h3)
		else $error("clearing operate bit did not inhibit");
	fault_reset_a: assert property (
		command_valid && cw[7] && !last_q[7] && sw[3]
		|-> ##2 sw[6] && !sw[3])
		else $error("reset edge did not clear fault");
	no_skip_a: assert property (
		command_valid && cw[0] && sw[3:0] == 4'h0 && !sw[6]
		|-> ##2 sw[2:0] == 3'h0)
		else $error("state skipped from not ready");
endmodule
`default_nettype wire

// ---- tb/tb_drive_status_word_sequencer.sv ----
// Bench: host and device ends joined by the link, driven over AXI.
// Assumes the package, interface and design modules compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_status_word_sequencer;
	import dsw_pkg::*;
	localparam int GUARD = 40;
	logic clk_i = 0;
	logic resetn_i = 0;
	logic fault_detect_i = 0, fault_reset_i = 0, alarm_i = 0, remote_i = 0;
	logic permit_i = 1, ce_i = 1;
	logic [15:0] actual_i = 0, reference_i = 0, tolerance_i = 0;
	logic [15:0] supervised_i = 0, limit_high_i = 8, limit_low_i = 4;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
	logic [31:0] wdata = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, run, rout, rin;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	dsw_state_t state;
	int n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'h2745, t_sent = 0;
	dsw_link_if link();
	dsw_device dsw_device_i (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.link(link), .fault_detect_i(fault_detect_i),
		.fault_reset_i(fault_reset_i), .alarm_i(alarm_i), .remote_i(remote_i),
		.external_run_permit_i(permit_i), .actual_i(actual_i),
		.reference_i(reference_i), .tolerance_i(tolerance_i),
		.supervised_i(supervised_i), .limit_high_i(limit_high_i),
		.limit_low_i(limit_low_i), .state_o(state), .run_o(run),
		.ramp_out_release_o(rout), .ramp_in_release_o(rin));
	dsw_host #(.GUARD_CYCLES(GUARD)) dsw_host_i (.clk_i(clk_i),
		.resetn_i(resetn_i), .ce_i(ce_i), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dsw_link_monitor dsw_link_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.command_word(link.command_word), .command_valid(link.command_valid),
		.status_word(link.status_word));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	// ------------------------------------
	// Shared tasks
	// ------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Expected input-driven status bits for one random draw
	function automatic logic [31:0] exp_flags(input logic [31:0] w,
		input logic h);
		logic [3:0] df;
		df = (w[7:4] > w[11:8]) ? w[7:4] - w[11:8] : w[11:8] - w[7:4];
		exp_flags = {19'h0, w[2], 1'b0, h, w[1], 1'b0, w[0], 7'h0};
		exp_flags[8] = df <= {2'h0, w[13:12]};
	endfunction
	task automatic limit(input int n);
		if (n > 200) begin
			n_fail++;
			$display("CHECK FAILED handshake expected answer seen none");
			stop_test();
		end
	endtask
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			limit(n);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			limit(n);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Polls the status register until the masked value shows up
	task automatic poll(input logic [31:0] m, v);
		logic [31:0] d;
		logic [1:0] r;
		int k;
		k = 0;
		do begin
			axi_read(4'h4, d, r);
			k++;
		end while ((d & m) !== v && k < 60);
		check("status", v, d & m);
		if ((d & m) !== v) stop_test();
	endtask
	task automatic cmd(input logic [15:0] w, input logic [31:0] m, v);
		logic [1:0] r;
		axi_write(4'h0, {16'h0000, w}, r);
		t_sent = cyc;
		repeat (4) @(posedge clk_i);
		poll(m, v);
	endtask
	task automatic do_reset();
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
	endtask
	// ------------------------------------
	// Main sequence
	// ------------------------------------
	initial begin
		logic [31:0] d, w, e;
		logic [15:0] sa, sl, sh;
		logic [1:0] r;
		logic hyst;
		int t0;
		do_reset();
		axi_read(4'h0, d, r);
		check("command reset", 32'h0, d);
		poll(32'h4f, 32'h0);
		for (int a = 8; a < 16; a += 4) begin
			axi_write(4'(a), 32'hffffffff, r);
			check("unmapped write", 32'h2, {30'h0, r});
			axi_read(4'(a), d, r);
			check("unmapped read", 32'h2, {d[29:0], r});
		end
		axi_write(4'h4, 32'hffff, r);
		check("status write", 32'h0, {30'h0, r});
		w = $random(seed);
		axi_write(4'h0, w, r);
		wstrb <= 4'h1;
		e = $random(seed);
		axi_write(4'h0, e, r);
		wstrb <= 4'hf;
		axi_read(4'h0, d, r);
		check("command readback", {16'h0, w[15:8], e[7:0]}, d);
		axi_read(4'h4, d, r);
		check("status spare", 32'h0, d & 32'hfffce000);
		$display("register map test done");
		do_reset();
		cmd(16'h0406, 32'h7f, 32'h31);
		t0 = t_sent;
		axi_write(4'h0, 32'h7, r);
		axi_read(4'h4, d, r);
		check("pending guard", 32'h3, {30'h0, d[17:16]});
		cmd(16'h0007, 32'h7f, 32'h33);
		check("guard wait", 32'h1, {31'h0, cyc - t0 > GUARD});
		cmd(16'h000f, 32'h7f, 32'h37);
		check("ramp held", 32'h4, {29'h0, run, rout, rin});
		cmd(16'h002f, 32'h7f, 32'h37);
		check("ramp out", 32'h6, {29'h0, run, rout, rin});
		cmd(16'h006f, 32'h7f, 32'h37);
		check("operating", {29'h0, DSW_OPERATING}, {29'h0, state});
		cmd(16'h002f, 32'h7f, 32'h37);
		check("ramp in held", 32'h6, {29'h0, run, rout, rin});
		cmd(16'h0867, 32'h87f, 32'h833);
		check("inhibit run", 32'h0, {31'h0, run});
		cmd(16'h000f, 32'h7f, 32'h37);
		permit_i <= 1'b0;
		poll(32'h7f, 32'h33);
		permit_i <= 1'b1;
		cmd(16'h000e, 32'h7f, 32'h31);
		cmd(16'h0005, 32'h7f, 32'h60);
		$display("start sequence test done");
		hyst = 1'b0;
		for (int i = 0; i < 24; i++) begin
			w = $random(seed);
			alarm_i <= w[0];
			remote_i <= w[1];
			permit_i <= w[2];
			actual_i <= {12'h0, w[7:4]};
			reference_i <= {12'h0, w[11:8]};
			tolerance_i <= {14'h0, w[13:12]};
			sa = {12'h0, w[19:16]};
			sl = {13'h0, w[22:20]};
			sh = sl + {13'h0, w[25:23]};
			supervised_i <= sa;
			limit_low_i <= sl;
			limit_high_i <= sh;
			hyst = (sa >= sh) | (hyst & (sa >= sl));
			e = exp_flags(w, hyst);
			repeat (3) @(posedge clk_i);
			axi_read(4'h4, d, r);
			check("status inputs", e, d & 32'h1780);
		end
		ce_i <= 1'b0;
		alarm_i <= ~alarm_i;
		repeat (3) @(posedge clk_i);
		check("frozen alarm", {31'h0, ~alarm_i},
			{31'h0, link.status_word[7]});
		ce_i <= 1'b1;
		$display("input flags test done");
		permit_i <= 1'b1;
		fault_detect_i <= 1'b1;
		poll(32'h4f, 32'h08);
		fault_detect_i <= 1'b0;
		cmd(16'h0080, 32'h7f, 32'h40);
		fault_detect_i <= 1'b1;
		poll(32'h4f, 32'h08);
		fault_detect_i <= 1'b0;
		fault_reset_i <= 1'b1;
		@(posedge clk_i);
		fault_reset_i <= 1'b0;
		poll(32'h4f, 32'h40);
		cmd(16'h000f, 32'h4f, 32'h40);
		cmd(16'h0006, 32'h7f, 32'h30);
		cmd(16'h000f, 32'h7f, 32'h30);
		$display("fault test done");
		stop_test();
	end
endmodule
`default_nettype wire
